// ### core/ncs_core.sv
// Nibble stack processor core with interrupt controller and bus slave.
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps

// Functional notes
// - Instruction pointer is 12 bits, steps per code byte, reloads on jumps.
// - Zero page short vector calls reach entries below 512 bytes.
// - Four 8-bit RAM pointers reach all 256 nibbles.
// - Operand pointer targets second element; pre-increment push, copy then pop.
// - Call pointer steps by four; fourth nibble of each entry stays unwritten.
// - Index fetch loads the head, store writes it; pre-inc and post-dec.
// - Flag nibble holds branch, carry, enable; direct ops and ALU update it.
// - Carry holds carry or borrow, is fifth shift bit, logic keeps it.
// - Conditional branch jumps only on branch flag; ALU ops update it.
// - Enable cleared by reset and mask-all, set by unmask-all or halt.
// - ALU works on top two elements and writes the stack head.
// - In and out instructions access one of 16 I/O addresses.
// - Machine cycle is two clocks; next byte prefetched during execution.
// - Eight fixed-priority levels, each with its own entry address.
// - Pending and active are 8 bits; requests sampled in non-I/O cycles.
// - Eligible enabled request runs an acknowledge cycle pushing the pointer.
// - Interrupt return clears the level's pending and active bits and returns.
// - Requests still latch as pending while enable is clear.
// - A request is lost while its pending bit or its not yet sampled held bit is still set.
// - Reset clears enable, pending and active.
// - Request to handler start takes three to five machine cycles.
// - Soft request writes the top two elements into pending.
// - Reset release runs a short vector call C1h to 008h.
module ncs_core
  import ncs_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Code memory.
  output logic      [11:0] code_addr_o,
  input  wire logic [7:0]  code_data_i,
  // Internal I/O bus.
  output ncs_io_t          io_o,
  input  wire logic [3:0]  io_rdata_i,
  // Interrupt requests.
  input  wire logic [7:0]  irq_i
);

  logic [3:0]  ram [256];
  logic [11:0] ip_q, ip_d;
  logic [7:0]  ir_q, ir_d;
  logic        irv_q, irv_d;
  ncs_state_t  st_q, st_d;
  logic [7:0]  sp_q, sp_d, rp_q, rp_d, x_q, x_d, y_q, y_d;
  logic [3:0]  tos_q, tos_d, flag_q, flag_d;
  logic [7:0]  pend_q, pend_d, act_q, act_d, hold_q, hold_d;
  ncs_io_t     io_q, io_d;
  logic        phase_q, run_q;
  ncs_wr_t     sw;
  logic        rw_en;
  logic [11:0] rw_val;
  logic [7:0]  clr, ackb, soft_request_op, ea;
  logic [4:0]  alu_r;

  function automatic logic [3:0] top_bit(input logic [7:0] v);
    top_bit = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        top_bit = {1'b1, 3'(i)};
      end
    end
  endfunction : top_bit

  // Decode and shared operands.
  wire        tick     = phase_q & run_q;
  wire [3:0]  grp      = ir_q[7:4];
  wire [3:0]  low      = ir_q[3:0];
  wire        is_short_vector_call = ir_q[7:6] == 2'b11;
  wire [7:0]  sp_inc   = sp_q + 8'd1;
  wire [7:0]  sp_dec   = sp_q - 8'd1;
  wire [7:0]  sp_dec2  = sp_q - 8'd2;
  wire [7:0]  rp_push  = rp_q + RSTK_STEP;
  wire [7:0]  rp_pop   = rp_q - RSTK_STEP;
  wire [3:0]  nos      = ram[sp_q];
  wire [3:0]  nos2     = ram[sp_dec];
  wire [11:0] ret_addr = {ram[rp_q], ram[rp_q + 8'd1], ram[rp_q + 8'd2]};
  wire [11:0] ip_inc   = ip_q + 12'd1;
  wire [11:0] far_tgt  = {low, code_data_i};
  wire [11:0] zp_tgt   = {3'b000, ir_q[5:0], 3'b000};
  wire [3:0]  pt       = top_bit(pend_q);
  wire [3:0]  at       = top_bit(act_q);
  wire        alu_ok   = low != ALU_NOP && low <= ALU_NOT;
  wire        alu_bin  = low >= ALU_ADD && low <= ALU_XOR;
  wire        alu_log  = (low >= ALU_AND && low <= ALU_XOR)
                       || low == ALU_NOT;
  wire [7:0]  mem_ptr  = low[3] ? y_q : x_q;

  // Highest pending level wins when above every active level.
  wire take = irv_q && st_q == ST_EXEC && flag_q[FL_I] && pt[3]
           && (!at[3] || pt[2:0] > at[2:0]);
  wire exec_now = irv_q && st_q == ST_EXEC && !take;
  wire io_cyc   = st_q == ST_IO
               || (exec_now && (grp == GRP_IN || grp == GRP_OUT));
  wire samp     = tick && !io_cyc;

  // Wishbone decode; writes land on the edge where the master sees ack.
  wire        wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wb_hit  = wb_cyc_i & wb_stb_i & wb_ack_o;
  wire        wr_ctrl = wb_hit & wb_we_i & wb_sel_i[0]
                      & (wb_adr_i == REG_CTRL);
  wire        wr_swrq = wb_hit & wb_we_i & wb_sel_i[0]
                      & (wb_adr_i == REG_SWREQ);
  wire [7:0]  inj     = wr_swrq ? wb_dat_i[7:0] : 8'h00;
  wire [31:0] rd_mux  =
      (wb_adr_i == REG_CTRL)  ? {31'h0000_0000, run_q} :
      (wb_adr_i == REG_SWREQ) ? {24'h00_0000, hold_q} :
      (wb_adr_i == REG_STAT)  ? {act_q, pend_q, flag_q, ip_q} :
      (wb_adr_i == REG_PTRS)  ? {sp_q, rp_q, x_q, y_q} :
                                32'h0000_0000;

  // Arithmetic unit on the top two elements.
  always_comb begin
    unique case (low)
      ALU_ADD: alu_r = {1'b0, nos} + {1'b0, tos_q};
      ALU_SUB: alu_r = {1'b0, nos} - {1'b0, tos_q};
      ALU_AND: alu_r = {flag_q[FL_C], nos & tos_q};
      ALU_OR:  alu_r = {flag_q[FL_C], nos | tos_q};
      ALU_XOR: alu_r = {flag_q[FL_C], nos ^ tos_q};
      ALU_SHL: alu_r = {tos_q, 1'b0};
      ALU_SHR: alu_r = {tos_q[0], 1'b0, tos_q[3:1]};
      ALU_ROL: alu_r = {tos_q, flag_q[FL_C]};
      ALU_ROR: alu_r = {tos_q[0], flag_q[FL_C], tos_q[3:1]};
      ALU_INC: alu_r = {1'b0, tos_q} + 5'd1;
      ALU_DEC: alu_r = {1'b0, tos_q} - 5'd1;
      ALU_NOT: alu_r = {flag_q[FL_C], ~tos_q};
      default: alu_r = {flag_q[FL_C], tos_q};
    endcase
  end

  assign ea = (low[1:0] == 2'b01) ? mem_ptr + 8'd1 : mem_ptr;

  // Sequencer: everything advances at the end of a machine cycle.
  always_comb begin
    ip_d   = ip_q;
    ir_d   = ir_q;
    irv_d  = irv_q;
    st_d   = st_q;
    sp_d   = sp_q;
    rp_d   = rp_q;
    x_d    = x_q;
    y_d    = y_q;
    tos_d  = tos_q;
    flag_d = flag_q;
    io_d   = io_q;
    sw     = '0;
    rw_en  = 1'b0;
    rw_val = ip_inc;
    clr    = 8'h00;
    ackb   = 8'h00;
    soft_request_op    = 8'h00;
    if (tick && st_q == ST_IO) begin
      io_d.wr = 1'b0;
      io_d.rd = 1'b0;
      st_d    = ST_EXEC;
      ir_d    = code_data_i;
      ip_d    = ip_inc;
      irv_d   = 1'b1;
      if (io_q.rd) begin
        sp_d  = sp_inc;
        sw    = '{1'b1, sp_inc, tos_q};
        tos_d = io_rdata_i;
      end
    end else if (tick && take) begin
      rw_en  = 1'b1;
      rw_val = ip_q - 12'd1;
      rp_d   = rp_push;
      ip_d   = IRQ_VEC[pt[2:0]];
      irv_d  = 1'b0;
      ackb   = 8'h01 << pt[2:0];
    end else if (tick && !irv_q) begin
      ir_d  = code_data_i;
      ip_d  = ip_inc;
      irv_d = 1'b1;
    end else if (tick) begin
      ir_d = code_data_i;
      ip_d = ip_inc;
      if (is_short_vector_call) begin
        rw_en  = 1'b1;
        rw_val = ip_q;
        rp_d   = rp_push;
        ip_d   = zp_tgt;
        irv_d  = 1'b0;
      end else begin
        unique case (grp)
          GRP_ALU: begin
            if (alu_ok) begin
              tos_d        = alu_r[3:0];
              flag_d[FL_C] = alu_r[4];
              flag_d[FL_B] = alu_log ? alu_r[3:0] == 4'h0
                                     : alu_r[4];
              if (alu_bin) begin
                sp_d = sp_dec;
              end
            end
          end
          GRP_LIT: begin
            sp_d  = sp_inc;
            sw    = '{1'b1, sp_inc, tos_q};
            tos_d = low;
          end
          GRP_STK: begin
            if (low == STK_DROP) begin
              tos_d = nos;
              sp_d  = sp_dec;
            end else if (low == STK_DUP) begin
              sp_d = sp_inc;
              sw   = '{1'b1, sp_inc, tos_q};
            end
          end
          GRP_MEM: begin
            if (low[2]) begin
              sw    = '{1'b1, ea, tos_q};
              tos_d = nos;
              sp_d  = sp_dec;
            end else begin
              sw    = '{1'b1, sp_inc, tos_q};
              sp_d  = sp_inc;
              tos_d = ram[ea];
            end
            if (low[1:0] != 2'b00) begin
              if (low[3]) begin
                y_d = (low[1:0] == 2'b01) ? ea : y_q - 8'd1;
              end else begin
                x_d = (low[1:0] == 2'b01) ? ea : x_q - 8'd1;
              end
            end
          end
          GRP_CTL: begin
            unique case (low)
              CTL_FORCE_BC: begin
                flag_d[FL_B] = 1'b1;
                flag_d[FL_C] = 1'b1;
              end
              CTL_FLIP_B:   flag_d[FL_B] = ~flag_q[FL_B];
              CTL_FLAG_WR: begin
                flag_d = tos_q;
                tos_d  = nos;
                sp_d   = sp_dec;
              end
              CTL_MASK_ALL: flag_d[FL_I] = 1'b0;
              CTL_UNMASK,
              CTL_HALT:     flag_d[FL_I] = 1'b1;
              CTL_IRET,
              CTL_RET: begin
                ip_d  = ret_addr;
                rp_d  = rp_pop;
                irv_d = 1'b0;
                if (low == CTL_IRET && at[3]) begin
                  clr = 8'h01 << at[2:0];
                end
              end
              CTL_FLAG_RD: begin
                sp_d  = sp_inc;
                sw    = '{1'b1, sp_inc, tos_q};
                tos_d = flag_q;
              end
              CTL_SOFT_REQ: begin
                soft_request_op   = {nos, tos_q};
                tos_d = nos2;
                sp_d  = sp_dec2;
              end
              CTL_LD_SP, CTL_LD_RP, CTL_LD_X, CTL_LD_Y: begin
                tos_d = nos2;
                sp_d  = sp_dec2;
                if (low == CTL_LD_RP) begin
                  rp_d = {nos, tos_q};
                end else if (low == CTL_LD_X) begin
                  x_d = {nos, tos_q};
                end else if (low == CTL_LD_Y) begin
                  y_d = {nos, tos_q};
                end else begin
                  sp_d = {nos, tos_q};
                end
              end
              default: ;
            endcase
          end
          GRP_IN: begin
            io_d = '{low, 4'h0, 1'b0, 1'b1};
            st_d = ST_IO;
            ir_d = ir_q;
            ip_d = ip_q;
          end
          GRP_OUT: begin
            io_d  = '{low, tos_q, 1'b1, 1'b0};
            st_d  = ST_IO;
            ir_d  = ir_q;
            ip_d  = ip_q;
            tos_d = nos;
            sp_d  = sp_dec;
          end
          GRP_BRC, GRP_JMP: begin
            irv_d = 1'b0;
            if (grp == GRP_JMP || flag_q[FL_B]) begin
              ip_d = far_tgt;
            end
          end
          GRP_CALL: begin
            rw_en = 1'b1;
            rp_d  = rp_push;
            ip_d  = far_tgt;
            irv_d = 1'b0;
          end
          default: ;
        endcase
      end
    end
  end

  // Set wins over clear on every pending and active bit.
  assign pend_d = (pend_q & ~clr) | (samp ? hold_q : 8'h00)
                | soft_request_op;
  assign act_d  = (act_q & ~clr) | ackb;
  assign hold_d = (samp ? 8'h00 : hold_q) | irq_i | inj;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ip_q    <= IP_RST;
      ir_q    <= OP_RESET_CALL;
      irv_q   <= 1'b1;
      st_q    <= ST_EXEC;
      sp_q    <= PTR_RST;
      rp_q    <= PTR_RST;
      x_q     <= PTR_RST;
      y_q     <= PTR_RST;
      tos_q   <= FLAG_RST;
      flag_q  <= FLAG_RST;
      pend_q  <= IRQ_RST;
      act_q   <= IRQ_RST;
      hold_q  <= IRQ_RST;
      io_q    <= '0;
      phase_q <= 1'b0;
    end else begin
      ip_q    <= ip_d;
      ir_q    <= ir_d;
      irv_q   <= irv_d;
      st_q    <= st_d;
      sp_q    <= sp_d;
      rp_q    <= rp_d;
      x_q     <= x_d;
      y_q     <= y_d;
      tos_q   <= tos_d;
      flag_q  <= flag_d;
      pend_q  <= pend_d;
      act_q   <= act_d;
      hold_q  <= hold_d;
      io_q    <= io_d;
      phase_q <= run_q ? ~phase_q : phase_q;
    end
  end

  // Data RAM; a call entry writes three nibbles and skips the fourth.
  always_ff @(posedge clk_i) begin
    if (tick && sw.en) begin
      ram[sw.addr] <= sw.data;
    end
    if (tick && rw_en) begin
      ram[rp_push]         <= rw_val[11:8];
      ram[rp_push + 8'd1]  <= rw_val[7:4];
      ram[rp_push + 8'd2]  <= rw_val[3:0];
    end
  end

  // Bus slave answers every access one clock after the strobe.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q    <= RUN_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : 32'h0000_0000;
      if (wr_ctrl) begin
        run_q <= wb_dat_i[0];
      end
    end
  end

  assign code_addr_o = ip_q;
  assign io_o        = io_q;

endmodule : ncs_core

// ### core/ncs_pkg.sv
// Shared constants and types of the nibble stack processor core.
package ncs_pkg;

  // Machine cycle length in system clocks.
  localparam int          CLKS_PER_MCYC = 2;

  // Reset values.
  localparam logic [11:0] IP_RST        = 12'h000;
  localparam logic [7:0]  OP_RESET_CALL = 8'hC1;
  localparam logic [7:0]  PTR_RST       = 8'h00;
  localparam logic [3:0]  FLAG_RST      = 4'h0;
  localparam logic [7:0]  IRQ_RST       = 8'h00;
  localparam logic        RUN_RST       = 1'b1;

  // Flag nibble bit positions.
  localparam int          FL_I          = 0;
  localparam int          FL_B          = 1;
  localparam int          FL_C          = 2;

  // Return stack step per entry.
  localparam logic [7:0]  RSTK_STEP     = 8'h04;

  // Opcode groups (upper nibble).
  localparam logic [3:0]  GRP_ALU       = 4'h0;
  localparam logic [3:0]  GRP_LIT       = 4'h1;
  localparam logic [3:0]  GRP_STK       = 4'h2;
  localparam logic [3:0]  GRP_MEM       = 4'h3;
  localparam logic [3:0]  GRP_CTL       = 4'h4;
  localparam logic [3:0]  GRP_IN        = 4'h5;
  localparam logic [3:0]  GRP_OUT       = 4'h6;
  localparam logic [3:0]  GRP_BRC       = 4'h8;
  localparam logic [3:0]  GRP_JMP       = 4'h9;
  localparam logic [3:0]  GRP_CALL      = 4'hA;

  // Arithmetic and logic operations (lower nibble).
  localparam logic [3:0]  ALU_NOP       = 4'h0;
  localparam logic [3:0]  ALU_ADD       = 4'h1;
  localparam logic [3:0]  ALU_SUB       = 4'h2;
  localparam logic [3:0]  ALU_AND       = 4'h3;
  localparam logic [3:0]  ALU_OR        = 4'h4;
  localparam logic [3:0]  ALU_XOR       = 4'h5;
  localparam logic [3:0]  ALU_SHL       = 4'h6;
  localparam logic [3:0]  ALU_SHR       = 4'h7;
  localparam logic [3:0]  ALU_ROL       = 4'h8;
  localparam logic [3:0]  ALU_ROR       = 4'h9;
  localparam logic [3:0]  ALU_INC       = 4'hA;
  localparam logic [3:0]  ALU_DEC       = 4'hB;
  localparam logic [3:0]  ALU_NOT       = 4'hC;

  // Stack group operations.
  localparam logic [3:0]  STK_DROP      = 4'h0;
  localparam logic [3:0]  STK_DUP       = 4'h1;

  // Control group operations.
  localparam logic [3:0]  CTL_FORCE_BC  = 4'h0;
  localparam logic [3:0]  CTL_FLIP_B    = 4'h1;
  localparam logic [3:0]  CTL_FLAG_WR   = 4'h2;
  localparam logic [3:0]  CTL_MASK_ALL  = 4'h3;
  localparam logic [3:0]  CTL_UNMASK    = 4'h4;
  localparam logic [3:0]  CTL_HALT      = 4'h5;
  localparam logic [3:0]  CTL_IRET      = 4'h6;
  localparam logic [3:0]  CTL_RET       = 4'h7;
  localparam logic [3:0]  CTL_FLAG_RD   = 4'h8;
  localparam logic [3:0]  CTL_SOFT_REQ  = 4'h9;
  localparam logic [3:0]  CTL_LD_SP     = 4'hC;
  localparam logic [3:0]  CTL_LD_RP     = 4'hD;
  localparam logic [3:0]  CTL_LD_X      = 4'hE;
  localparam logic [3:0]  CTL_LD_Y      = 4'hF;

  // Handler entry addresses, level 7 highest.
  localparam logic [7:0][11:0] IRQ_VEC = {
    12'h1E0, 12'h1C0, 12'h180, 12'h140,
    12'h100, 12'h0C0, 12'h080, 12'h040};

  // Wishbone register byte offsets.
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_SWREQ     = 4'h4;
  localparam logic [3:0]  REG_STAT      = 4'h8;
  localparam logic [3:0]  REG_PTRS      = 4'hC;

  typedef enum logic [0:0] {
    ST_EXEC = 1'b0,
    ST_IO   = 1'b1
  } ncs_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [3:0] wdata;
    logic       wr;
    logic       rd;
  } ncs_io_t;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [3:0] data;
  } ncs_wr_t;

endpackage : ncs_pkg

// ### verification/ncs_core_props.sv
// Port-level assertions for the nibble stack processor core.
`timescale 1ns/1ps
module ncs_core_props
  import ncs_pkg::*;
(
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // Wishbone slave.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Code and I/O buses.
  input wire logic [11:0] code_addr_o,
  input wire ncs_io_t     io_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_mcycle_two_clk: assert property (
    $changed(code_addr_o) |=> $stable(code_addr_o))
    else $error("code address changed on two edges in a row");
  a_reset_vector: assert property (
    $rose(rst_n_i) |-> ##[1:3] code_addr_o == 12'h008)
    else $error("no short call to 008 after reset");
  a_io_wr_len: assert property (
    $rose(io_o.wr) |=> io_o.wr ##1 !io_o.wr)
    else $error("write strobe not one machine cycle");
  a_io_rd_len: assert property (
    $rose(io_o.rd) |=> io_o.rd ##1 !io_o.rd)
    else $error("read strobe not one machine cycle");
  a_io_strobe_excl: assert property (
    !(io_o.wr && io_o.rd))
    else $error("read and write strobes together");
  a_io_addr_hold: assert property (
    $rose(io_o.wr) |=> $stable(io_o.addr) && $stable(io_o.wdata))
    else $error("I/O address or data moved during write");
  a_wb_ack_req: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one clock");
  a_wb_ack_once: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one clock");
  a_wb_dat_idle: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside acknowledge");

  c_io_write: cover property ($rose(io_o.wr));
  c_io_read: cover property ($rose(io_o.rd));
  c_vec_entry: cover property (code_addr_o == 12'h180);
  c_wb_read: cover property (wb_ack_o && !wb_we_i);
endmodule : ncs_core_props

// ### verification/ncs_io_model.sv
// Peripheral register file on the far side of the internal I/O bus.
`timescale 1ns/1ps
module ncs_io_model
  import ncs_pkg::*;
#(
  parameter logic [3:0] REG7_RST = 4'hB
)
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // I/O bus.
  input  wire ncs_io_t    io_i,
  output logic      [3:0] rdata_o
);
  logic [3:0] regs_q [16];
  logic [7:0] log_q [$];
  logic       wr_q;
  logic [3:0] last_q;

  // Sixteen nibble registers, one per primary address; writes are logged.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q   <= 1'b0;
      last_q <= 4'h0;
      foreach (regs_q[i]) regs_q[i] <= (i == 7) ? REG7_RST : 4'h0;
    end else begin
      wr_q <= io_i.wr;
      if (io_i.wr && !wr_q) begin
        regs_q[io_i.addr] <= io_i.wdata;
        log_q.push_back({io_i.addr, io_i.wdata});
      end
      if (io_i.rd) last_q <= regs_q[io_i.addr];
    end
  end

  // Outside a read the line shows the inverse of the last value read.
  assign rdata_o = io_i.rd ? regs_q[io_i.addr] : ~last_q;
endmodule : ncs_io_model

// ### verification/testbench.sv
// Self-checking testbench of the nibble stack processor core.
`timescale 1ns/1ps
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
  end \
end

module testbench
  import ncs_pkg::*;
;
  logic        clk_i;
  logic        rst_n_i;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [3:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic [11:0] code_addr;
  logic [7:0]  code_data;
  ncs_io_t     io;
  logic [3:0]  io_rdata;
  logic [7:0]  irq;
  logic [7:0]  rom [4096];
  logic [7:0]  exp_log [8];
  logic [31:0] s1;
  logic [31:0] s2;
  int          fails;
  int          cmp_count;
  int          n;

  ncs_core u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
    .code_addr_o(code_addr), .code_data_i(code_data), .io_o(io),
    .io_rdata_i(io_rdata), .irq_i(irq));

  ncs_io_model u_io (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .io_i(io), .rdata_o(io_rdata));

  assign code_data = rom[code_addr];

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // One classic Wishbone cycle; held until ack is sampled high.
  task automatic wb_acc(input logic we, input logic [3:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= a;
    wb_dat_w <= d;
    wb_sel   <= 4'hF;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge clk_i);
  endtask : wb_acc

  task automatic wait_pc(input logic [11:0] a, output int k);
    k = 0;
    while (code_addr !== a && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
  endtask : wait_pc

  task automatic put(input logic [11:0] a, input logic [7:0] b[$]);
    foreach (b[i]) rom[a + 12'(i)] = b[i];
  endtask : put

  task automatic wait_log(input int k);
    while (u_io.log_q.size() < k) @(posedge clk_i);
    repeat (20) @(posedge clk_i);
  endtask : wait_log

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    report_and_stop();
  end

  initial begin
    fails = 0;
    cmp_count = 0;
    rst_n_i = 1'b0;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w, irq} = '0;
    exp_log = '{8'h08, 8'h26, 8'h34, 8'h5B, 8'h45, 8'h43, 8'h41, 8'h46};
    foreach (rom[i]) rom[i] = 8'h00;
    // Stack pointers set first, then add, carry, logic, IN and branches.
    put(12'h008, '{8'h1F, 8'h1C, 8'h4D, 8'h12, 8'h10, 8'h4C,
                   8'h13, 8'h15, 8'h01, 8'h60, 8'h19, 8'h19, 8'h01,
                   8'h48, 8'h62, 8'h19, 8'h19, 8'h01, 8'h1F, 8'h11,
                   8'h03, 8'h48, 8'h63, 8'h57, 8'h65, 8'h80, 8'h30,
                   8'h40, 8'h82, 8'h00});
    put(12'h030, '{8'h1E, 8'h66});
    put(12'h200, '{8'h10, 8'h12, 8'h49});
    put(12'h280, '{8'h44});
    put(12'h080, '{8'h11, 8'h64, 8'h46});
    put(12'h100, '{8'h13, 8'h64, 8'h46});
    put(12'h140, '{8'h14, 8'h64, 8'h46});
    put(12'h180, '{8'h15, 8'h64, 8'h46});
    put(12'h1C0, '{8'h16, 8'h64, 8'h46});
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wait_pc(12'h008, n);
    `CHK(n <= 4, 1'b1)
    wait_log(1);
    wb_acc(1'b0, REG_PTRS, 32'h0, s1);
    `CHK(s1[23:16], 8'hFC)
    wait_pc(12'h210, n);
    irq <= 8'h28;
    @(posedge clk_i);
    irq <= 8'h00;
    @(posedge clk_i);
    irq <= 8'h08;
    @(posedge clk_i);
    irq <= 8'h00;
    repeat (4) @(posedge clk_i);
    wb_acc(1'b0, REG_STAT, 32'h0, s1);
    `CHK(s1[31:12], 20'h0_02A6)
    wait_log(7);
    wb_acc(1'b0, REG_STAT, 32'h0, s1);
    `CHK(s1[31:12], 20'h0_0007)
    irq <= 8'h40;
    @(posedge clk_i);
    irq <= 8'h00;
    wait_pc(12'h1C0, n);
    `CHK(n <= 10, 1'b1)
    wait_log(8);
    foreach (exp_log[i]) `CHK(u_io.log_q[i], exp_log[i])
    `CHK(u_io.log_q.size(), 8)
    wb_acc(1'b1, REG_CTRL, 32'h0, s1);
    wb_acc(1'b0, REG_STAT, 32'h0, s1);
    wb_acc(1'b1, REG_SWREQ, 32'h0000_0010, s2);
    wb_acc(1'b0, REG_SWREQ, 32'h0, s2);
    `CHK(s2, 32'h0000_0010)
    wb_acc(1'b0, REG_STAT, 32'h0, s2);
    `CHK(s2[11:0], s1[11:0])
    wb_acc(1'b1, REG_CTRL, 32'h1, s2);
    wait_log(9);
    `CHK(u_io.log_q[8], 8'h44)
    wb_acc(1'b0, REG_STAT, 32'h0, s2);
    `CHK(s2[11:0] != s1[11:0], 1'b1)
    wb_acc(1'b1, REG_STAT, 32'hFFFF_FFFF, s1);
    wb_acc(1'b0, 4'h2, 32'h0, s1);
    `CHK(s1, 32'h0000_0000)
    wb_acc(1'b0, REG_STAT, 32'h0, s1);
    `CHK(s1[31:16], 16'h0000)
    irq <= 8'h01;
    @(posedge clk_i);
    irq <= 8'h00;
    repeat (10) @(posedge clk_i);
    wb_acc(1'b0, REG_STAT, 32'h0, s1);
    `CHK(s1[31:16], 16'h0101)
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wb_acc(1'b0, REG_STAT, 32'h0, s1);
    `CHK(s1[31:12], 20'h0_0000)
    report_and_stop();
  end
endmodule : testbench

bind ncs_core ncs_core_props u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .code_addr_o(code_addr_o), .io_o(io_o));
